// ---- src/adc_seq_pkg.sv ----
// constants, register map and carrier types for the converter sequencer
package adc_seq_pkg;
   // register addresses in the register-addressing space
   localparam logic [7:0] RES_HIGH_ADDR = 8'hd0;
   localparam logic [7:0] RES_LOW_ADDR  = 8'hd1;
   localparam logic [7:0] CTRL_ADDR     = 8'hd2;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] RES_RESET     = 8'h00;
   // control register field positions
   localparam int CHAN_MSB  = 7;
   localparam int CHAN_LSB  = 4;
   localparam int EOC_BIT   = 3;
   localparam int CLK_MSB   = 2;
   localparam int CLK_LSB   = 1;
   localparam int START_BIT = 0;
   // channel space: codes 0..8 valid, above reserved
   localparam int         NUM_CHANNELS = 9;
   localparam logic [3:0] CHAN_MAX     = 4'h8;
   // conversion shape
   localparam int         RES_BITS      = 10;
   localparam logic [9:0] SAR_MIDSCALE  = 10'h200;
   localparam logic [3:0] SETUP_TICKS   = 4'ha;
   localparam logic [3:0] TICKS_PER_BIT = 4'h4;
   localparam logic [3:0] TOP_BIT       = 4'h9;
   localparam logic [5:0] RES_LOW_PAD   = 6'h00;
   // conversion clock select codes and divisors
   localparam logic [1:0] CLK_DIV16 = 2'h0;
   localparam logic [1:0] CLK_DIV8  = 2'h1;
   localparam logic [1:0] CLK_DIV4  = 2'h2;
   localparam logic [1:0] CLK_DIV1  = 2'h3;
   localparam logic [3:0] DIV16_TERM = 4'hf;
   localparam logic [3:0] DIV8_TERM  = 4'h7;
   localparam logic [3:0] DIV4_TERM  = 4'h3;
   localparam logic [3:0] DIV1_TERM  = 4'h0;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SETUP = 2'b01,
      ST_TRIAL = 2'b11,
      ST_DONE  = 2'b10
   } seq_state_t;

   typedef struct packed {
      logic [3:0] chan;
      logic       eoc;
      logic [1:0] clk_sel;
      logic       start;
   } ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [3:0] cnt;
      logic       tick;
   } div_state_t;

   typedef struct packed {
      ctrl_t      ctrl;
      seq_state_t state;
      logic [3:0] conv_chan;
      logic [9:0] sar;
      logic [3:0] bit_idx;
      logic [3:0] cnt;
      logic [7:0] res_high;
      logic [7:0] res_low;
      logic [7:0] rd_data;
      logic [8:0] mux_sel;
      logic       busy;
      logic       cmp_meta;
      logic       cmp_sync;
   } seq_regs_t;
endpackage

// ---- src/conv_clock_divider.sv ----
// conversion clock tick generator: system clock divided by 16, 8, 4 or 1
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider (
   input  wire logic       clk_in,      // system clock
   input  wire logic       arst_n_in,   // async reset, active low
   input  wire logic       restart_in,  // realign phase at conversion start
   input  wire logic [1:0] div_sel_in,  // clock select code
   output logic            tick_out     // one-cycle conversion clock tick
);
   adc_seq_pkg::div_state_t cur_ff, nxt_s;

   // last count value of the divider for a select code
   function automatic logic [3:0] div_term(input logic [1:0] sel);
      case (sel)
         adc_seq_pkg::CLK_DIV16: div_term = adc_seq_pkg::DIV16_TERM;
         adc_seq_pkg::CLK_DIV8:  div_term = adc_seq_pkg::DIV8_TERM;
         adc_seq_pkg::CLK_DIV4:  div_term = adc_seq_pkg::DIV4_TERM;
         default:                div_term = adc_seq_pkg::DIV1_TERM;
      endcase
   endfunction

   // restart keeps the first setup tick a full period away
   always_comb begin
      nxt_s = cur_ff;
      if (restart_in) begin
         nxt_s.cnt  = 4'h0;
         nxt_s.tick = 1'b0;
      end else if (cur_ff.cnt >= div_term(div_sel_in)) begin
         nxt_s.cnt  = 4'h0;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.cnt  = cur_ff.cnt + 4'h1;
         nxt_s.tick = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_s;
      end
   end

   assign tick_out = cur_ff.tick;

   a_div_period: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (tick_out && div_sel_in == adc_seq_pkg::CLK_DIV4 && !restart_in)[*1] ##1
      (!restart_in && div_sel_in == adc_seq_pkg::CLK_DIV4)[*3] |-> ##1 tick_out)
      else $error("divide-by-4 tick period wrong");
   a_div_one: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (div_sel_in == adc_seq_pkg::CLK_DIV1 && !restart_in) |=> tick_out)
      else $error("divide-by-1 tick missing");
endmodule
`default_nettype wire

// ---- src/sar_adc_sequencer.sv ----
// successive-approximation converter sequencer with control and result registers
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer (
   input  wire logic                  clk_in,               // system clock, 100 MHz
   input  wire logic                  arst_n_in,            // async reset, active low
   input  wire adc_seq_pkg::reg_req_t reg_req_in,           // register write request
   input  wire logic [7:0]            reg_rd_addr_in,       // register read address
   input  wire logic [8:0]            analog_pin_enable_in, // per-pin analog enable
   input  wire logic                  comparator_in,        // analog comparator, async
   output logic [7:0]                 rd_data_out,          // registered read data
   output logic [9:0]                 dac_code_out,         // resistor-string code
   output logic [8:0]                 mux_sel_out,          // one-hot analog input switch
   output logic                       busy_out              // conversion in progress
);
   adc_seq_pkg::seq_regs_t cur_ff, nxt_s;
   logic tick;
   logic wr_ctrl;
   logic start_req;

   // one-hot input switch; reserved codes close no switch
   function automatic logic [8:0] chan_onehot(input logic [3:0] chan);
      chan_onehot = '0;
      if (chan <= adc_seq_pkg::CHAN_MAX) begin
         chan_onehot[chan] = 1'b1;
      end
   endfunction

   // register read decode; unmapped addresses read zero
   function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                           input adc_seq_pkg::seq_regs_t r);
      case (addr)
         adc_seq_pkg::CTRL_ADDR:     read_mux = r.ctrl;
         adc_seq_pkg::RES_HIGH_ADDR: read_mux = r.res_high;
         adc_seq_pkg::RES_LOW_ADDR:  read_mux = r.res_low;
         default:                    read_mux = 8'h00;
      endcase
   endfunction

   // write decode shared by the register update and the sequencer
   assign wr_ctrl   = reg_req_in.wr && (reg_req_in.addr == adc_seq_pkg::CTRL_ADDR);
   assign start_req = wr_ctrl && reg_req_in.wdata[adc_seq_pkg::START_BIT] &&
                      (cur_ff.state == adc_seq_pkg::ST_IDLE);

   conv_clock_divider u_div (
      .clk_in     (clk_in),
      .arst_n_in  (arst_n_in),
      .restart_in (start_req),
      .div_sel_in (cur_ff.ctrl.clk_sel),
      .tick_out   (tick)
   );

   // sequencer, control register and result capture
   always_comb begin
      nxt_s = cur_ff;
      // two-stage synchroniser for the comparator decision
      nxt_s.cmp_meta = comparator_in;
      nxt_s.cmp_sync = cur_ff.cmp_meta;
      // writable fields; done flag ignores software writes
      if (wr_ctrl) begin
         nxt_s.ctrl.chan    = reg_req_in.wdata[adc_seq_pkg::CHAN_MSB:adc_seq_pkg::CHAN_LSB];
         nxt_s.ctrl.clk_sel = reg_req_in.wdata[adc_seq_pkg::CLK_MSB:adc_seq_pkg::CLK_LSB];
         nxt_s.ctrl.start   = reg_req_in.wdata[adc_seq_pkg::START_BIT];
      end
      case (cur_ff.state)
         adc_seq_pkg::ST_IDLE: begin
            if (start_req) begin
               nxt_s.state     = adc_seq_pkg::ST_SETUP;
               nxt_s.conv_chan = reg_req_in.wdata[adc_seq_pkg::CHAN_MSB:adc_seq_pkg::CHAN_LSB];
               nxt_s.sar       = adc_seq_pkg::SAR_MIDSCALE;
               nxt_s.bit_idx   = adc_seq_pkg::TOP_BIT;
               nxt_s.cnt       = 4'h0;
               nxt_s.ctrl.eoc  = 1'b0;
            end
         end
         adc_seq_pkg::ST_SETUP: begin
            if (tick) begin
               if (cur_ff.cnt == adc_seq_pkg::SETUP_TICKS - 4'h1) begin
                  nxt_s.state = adc_seq_pkg::ST_TRIAL;
                  nxt_s.cnt   = 4'h0;
               end else begin
                  nxt_s.cnt = cur_ff.cnt + 4'h1;
               end
            end
         end
         adc_seq_pkg::ST_TRIAL: begin
            // the code settles for three ticks; the decision is sampled on the fourth
            if (tick) begin
               if (cur_ff.cnt == adc_seq_pkg::TICKS_PER_BIT - 4'h1) begin
                  nxt_s.cnt = 4'h0;
                  if (!cur_ff.cmp_sync) begin
                     nxt_s.sar[cur_ff.bit_idx] = 1'b0;
                  end
                  if (cur_ff.bit_idx == 4'h0) begin
                     nxt_s.state = adc_seq_pkg::ST_DONE;
                  end else begin
                     nxt_s.bit_idx                    = cur_ff.bit_idx - 4'h1;
                     nxt_s.sar[cur_ff.bit_idx - 4'h1] = 1'b1;
                  end
               end else begin
                  nxt_s.cnt = cur_ff.cnt + 4'h1;
               end
            end
         end
         adc_seq_pkg::ST_DONE: begin
            // each completion overwrites the previous result
            nxt_s.res_high = cur_ff.sar[9:2];
            nxt_s.res_low  = {cur_ff.sar[1:0], adc_seq_pkg::RES_LOW_PAD};
            nxt_s.ctrl.eoc = 1'b1;
            nxt_s.state    = adc_seq_pkg::ST_IDLE;
         end
         default: begin
            nxt_s.state = adc_seq_pkg::ST_IDLE;
         end
      endcase
      // clearing the start bit aborts a conversion at once
      if (wr_ctrl && !reg_req_in.wdata[adc_seq_pkg::START_BIT] &&
          cur_ff.state != adc_seq_pkg::ST_IDLE) begin
         nxt_s.state = adc_seq_pkg::ST_IDLE;
      end
      // only the converting pin, and only if analog-enabled, is switched in
      nxt_s.busy    = (nxt_s.state != adc_seq_pkg::ST_IDLE);
      nxt_s.mux_sel = nxt_s.busy ? (chan_onehot(nxt_s.conv_chan) & analog_pin_enable_in)
                                 : 9'h000;
      nxt_s.rd_data = read_mux(reg_rd_addr_in, cur_ff);
   end

   // every field clears on reset: start off, channel 0, divide by 16
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cur_ff          <= '0;
         cur_ff.ctrl     <= adc_seq_pkg::CTRL_RESET;
         cur_ff.state    <= adc_seq_pkg::ST_IDLE;
         cur_ff.res_high <= adc_seq_pkg::RES_RESET;
         cur_ff.res_low  <= adc_seq_pkg::RES_RESET;
      end else begin
         cur_ff <= nxt_s;
      end
   end

   assign rd_data_out  = cur_ff.rd_data;
   assign dac_code_out = cur_ff.sar;
   assign mux_sel_out  = cur_ff.mux_sel;
   assign busy_out     = cur_ff.busy;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   a_start_midscale: assert property (start_req |=>
      (dac_code_out == adc_seq_pkg::SAR_MIDSCALE && busy_out && !cur_ff.ctrl.eoc))
      else $error("conversion did not start at midscale");
   a_setup_ten: assert property ((cur_ff.state == adc_seq_pkg::ST_SETUP && tick &&
      cur_ff.cnt == 4'h9 && !wr_ctrl) |=> cur_ff.state == adc_seq_pkg::ST_TRIAL)
      else $error("setup did not last ten ticks");
   a_trial_decide: assert property ((cur_ff.state == adc_seq_pkg::ST_TRIAL && tick &&
      cur_ff.cnt == 4'h3 && !cur_ff.cmp_sync && cur_ff.bit_idx == 4'h9 && !wr_ctrl)
      |=> (dac_code_out[9:8] == 2'b01))
      else $error("msb trial did not resolve low");
   a_done_result: assert property ((cur_ff.state == adc_seq_pkg::ST_DONE) |=>
      (cur_ff.res_high == $past(cur_ff.sar[9:2]) && cur_ff.res_low[5:0] == 6'h00 &&
       cur_ff.ctrl.eoc && !busy_out))
      else $error("result capture or idle return wrong");
   a_eoc_hold: assert property ((cur_ff.ctrl.eoc && !start_req) |=> cur_ff.ctrl.eoc)
      else $error("done flag dropped without a start");
   a_stop_abort: assert property ((wr_ctrl && !reg_req_in.wdata[0] && busy_out)
      |=> (!busy_out && mux_sel_out == 9'h000))
      else $error("disable did not abort conversion");
   a_one_channel: assert property ($onehot0(mux_sel_out) &&
      ((mux_sel_out & ~analog_pin_enable_in) == 9'h000 || $changed(analog_pin_enable_in)))
      else $error("more than one or non-analog pin switched");
   a_reserved_chan: assert property ((busy_out && cur_ff.conv_chan > 4'h8) |->
      mux_sel_out == 9'h000)
      else $error("reserved channel closed a switch");
   a_read_high: assert property ((reg_rd_addr_in == adc_seq_pkg::RES_HIGH_ADDR) |=>
      rd_data_out == $past(cur_ff.res_high))
      else $error("high byte read wrong");
   // read-back of the low byte and the control register, one cycle after the address
   a_read_low: assert property ((reg_rd_addr_in == adc_seq_pkg::RES_LOW_ADDR) |=>
      rd_data_out == $past(cur_ff.res_low))
      else $error("low byte read wrong");
   a_read_ctrl: assert property ((reg_rd_addr_in == adc_seq_pkg::CTRL_ADDR) |=>
      rd_data_out == $past(cur_ff.ctrl))
      else $error("control read wrong");
   // a write without start while idle must not touch the done flag
   a_eoc_readonly: assert property ((wr_ctrl && !reg_req_in.wdata[0] && !busy_out) |=>
      cur_ff.ctrl.eoc == $past(cur_ff.ctrl.eoc))
      else $error("software write changed the done flag");
   // the latched channel holds for the whole conversion
   a_chan_latched: assert property ((busy_out && $past(busy_out)) |->
      $stable(cur_ff.conv_chan))
      else $error("converting channel changed mid-run");
   a_trial_stable: assert property ((cur_ff.state == adc_seq_pkg::ST_TRIAL && !tick) |=>
      $stable(dac_code_out))
      else $error("trial code moved between ticks");
   a_switch_chan: assert property ((busy_out && mux_sel_out != 9'h000) |->
      mux_sel_out == (9'h001 << cur_ff.conv_chan))
      else $error("switch does not match latched channel");

   c_full_conv: cover property (cur_ff.state == adc_seq_pkg::ST_DONE);
   c_abort: cover property (busy_out ##1 !busy_out && !cur_ff.ctrl.eoc);
   c_div1_start: cover property (start_req && cur_ff.ctrl.clk_sel == adc_seq_pkg::CLK_DIV1);
   c_top_code: cover property (cur_ff.state == adc_seq_pkg::ST_DONE && &cur_ff.sar);
   c_reserved_conv: cover property (start_req && reg_req_in.wdata[7:4] > 4'h8);
endmodule
`default_nettype wire

// ---- tb/adc_frontend_model.sv ----
// behavioural comparator and resistor string seen by the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_frontend_model (
   input  wire logic        clk_in,         // system clock
   input  wire logic [89:0] levels_in,      // ten-bit level of each analog input
   input  wire logic [9:0]  dac_code_in,    // resistor-string tap code
   input  wire logic [8:0]  mux_sel_in,     // one-hot input switch
   output logic             comparator_out  // 1 when input >= tap voltage
);
   logic float_ff;
   // an open comparator input is not a steady 0; toggling keeps it from hiding faults
   always @(posedge clk_in) begin
      float_ff <= (float_ff === 1'b1) ? 1'b0 : 1'b1;
   end
   // compare the switched-in level with the tap voltage; tap code n is n/1024 of reference
   always_comb begin
      comparator_out = float_ff;
      for (int i = 0; i < 9; i++) begin
         if (mux_sel_in === (9'h001 << i)) begin
            comparator_out = (levels_in[i*10 +: 10] >= dac_code_in);
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the converter sequencer against an integer model
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                  clk_in;
   logic                  arst_n_in;
   adc_seq_pkg::reg_req_t reg_req_in;
   logic [7:0]            rd_addr;
   logic [8:0]            pin_en;
   logic                  cmp;
   logic [7:0]            rd_data;
   logic [9:0]            dac;
   logic [8:0]            mux;
   logic                  busy;
   logic [89:0]           levels;
   int                    lvl [9];
   int                    err_total;
   int                    n_checks;

   sar_adc_sequencer dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_req_in(reg_req_in),
      .reg_rd_addr_in(rd_addr), .analog_pin_enable_in(pin_en), .comparator_in(cmp),
      .rd_data_out(rd_data), .dac_code_out(dac), .mux_sel_out(mux), .busy_out(busy));
   adc_frontend_model frontend (.clk_in(clk_in), .levels_in(levels), .dac_code_in(dac),
      .mux_sel_in(mux), .comparator_out(cmp));

   task automatic check(input string name, input logic [15:0] seen, input int exp);
      n_checks++;
      if (seen !== 16'(exp)) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, 16'(exp), seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // one-cycle write strobe; a free edge always separates two writes
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      reg_req_in = '{addr: a, wr: 1'b1, wdata: d};
      @(posedge clk_in);
      #1;
      reg_req_in.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      #1;
      rd_addr = a;
      @(posedge clk_in);
      #1;
      d = rd_data;
   endtask

   // pins first, then channel, then start; result read back in full, if a switch was closed, before the next start
   task automatic conv(input int ch, input int cs, input logic [8:0] en);
      logic [7:0] d;
      logic [8:0] oh;
      int         cnt;
      int         n;
      n = (cs == 0) ? 16 : (cs == 1) ? 8 : (cs == 2) ? 4 : 1;
      oh = (ch < 9) ? (9'h001 << ch) : 9'h000;
      pin_en = en;
      wr(8'hd2, 8'((ch << 4) | (cs << 1)));
      wr(8'hd2, 8'((ch << 4) | (cs << 1) | 1));
      check("busy start", busy, 1);
      check("dac start", dac, 'h200);
      check("mux start", mux, oh & en);
      cnt = 0;
      while (busy === 1'b1 && cnt < 2000) begin
         @(posedge clk_in);
         #1;
         cnt++;
      end
      if (cnt >= 2000) begin
         err_total++;
         summarize();
      end
      check("conv length", (cnt >= 50 * n - 1) && (cnt <= 50 * n + 4), 1);
      check("mux idle", mux, 0);
      if ((oh & en) != 9'h000) begin
         rd(8'hd0, d);
         check("result high", d, (lvl[ch] >> 2) & 'hff);
         rd(8'hd1, d);
         check("result low", d, (lvl[ch] & 3) << 6);
      end
      rd(8'hd2, d);
      check("control done", d, (ch << 4) | 8 | (cs << 1) | 1);
   endtask

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   initial begin
      logic [7:0] d;
      logic [7:0] addrs [4];
      arst_n_in = 1'b0;
      reg_req_in = '0;
      rd_addr = 8'h00;
      pin_en = 9'h000;
      err_total = 0;
      n_checks = 0;
      void'($urandom(32'h08a2_87e0));
      // random levels, with both ends of the range on the outer channels
      for (int i = 0; i < 9; i++) begin
         lvl[i] = $urandom_range(1023, 0);
      end
      lvl[0] = 0;
      lvl[8] = 1023;
      for (int i = 0; i < 9; i++) begin
         levels[i*10 +: 10] = 10'(lvl[i]);
      end
      repeat (3) @(posedge clk_in);
      #1;
      arst_n_in = 1'b1;
      // reset values, unmapped address reads zero
      addrs = '{8'hd0, 8'hd1, 8'hd2, 8'hd5};
      foreach (addrs[i]) begin
         rd(addrs[i], d);
         check("reset read", d, 0);
      end
      // every channel, every clock divider, channel changed between conversions
      for (int ch = 0; ch < 9; ch++) begin
         conv(ch, ch % 4, 9'($urandom) | (9'h001 << ch));
      end
      // result bytes and done flag ignore writes
      wr(8'hd0, 8'h00);
      wr(8'hd1, 8'h3f);
      wr(8'hd2, 8'h80);
      rd(8'hd0, d);
      check("high read-only", d, 'hff);
      rd(8'hd1, d);
      check("low read-only", d, 'hc0);
      rd(8'hd2, d);
      check("done flag kept", d, 'h88);
      // clearing the start bit mid-run aborts and leaves the old result
      wr(8'hd2, 8'h27);
      repeat (5) @(posedge clk_in);
      #1;
      wr(8'hd2, 8'h26);
      @(posedge clk_in);
      #1;
      check("busy abort", busy, 0);
      rd(8'hd2, d);
      check("abort control", d, 'h26);
      rd(8'hd0, d);
      check("abort result", d, 'hff);
      // reserved channel code and a pin left digital close no switch
      conv(12, 3, 9'h1ff);
      conv(3, 3, 9'h1f7);
      // the converter is checked to be idle, then the run stops
      check("idle at end", busy, 0);
      summarize();
   end
endmodule
`default_nettype wire
